// [common/debug_status_port_defines.vh]
// constants for the debug status port block
`ifndef DEBUG_STATUS_PORT_DEFINES_VH
`define DEBUG_STATUS_PORT_DEFINES_VH

// test-port controller states
`define TAP_RESET      4'h0
`define TAP_IDLE       4'h1
`define TAP_SEL_DR     4'h2
`define TAP_CAP_DR     4'h3
`define TAP_SHIFT_DR   4'h4
`define TAP_EXIT1_DR   4'h5
`define TAP_PAUSE_DR   4'h6
`define TAP_EXIT2_DR   4'h7
`define TAP_UPD_DR     4'h8
`define TAP_SEL_IR     4'h9
`define TAP_CAP_IR     4'ha
`define TAP_SHIFT_IR   4'hb
`define TAP_EXIT1_IR   4'hc
`define TAP_PAUSE_IR   4'hd
`define TAP_EXIT2_IR   4'he
`define TAP_UPD_IR     4'hf

// instruction register
`define IR_WIDTH       4
`define IR_CAPTURE     4'h1
`define IR_BYPASS      4'hf
`define IR_RESET_VAL   4'hf

// status values
`define PST_HALTED     4'hf
`define PST_START_C    4'hc
`define PST_START_D    4'hd
`define PST_IDLE       4'h0

// debug serial packet length
`define DBG_PKT_BITS   17
`define DBG_CNT_W      5

`endif

// [core/dbg_serial_port.v]
// debug serial port: pin sync, clock qualifier and 17-bit shifter
`timescale 1ns/1ns
`default_nettype none
`include "debug_status_port_defines.vh"

module dbg_serial_port (
    // clock and reset
    input  wire                      mclk,
    input  wire                      reset_n,
    // pins
    input  wire                      dbg_serial_clock,
    input  wire                      dbg_serial_in,
    output reg                       dbg_serial_out,
    // user side
    input  wire [`DBG_PKT_BITS-1:0]  resp_data,
    output reg  [`DBG_PKT_BITS-1:0]  rx_data,
    output reg                       rx_valid
);

    reg [1:0] clk_sync_reg;
    reg [1:0] din_sync_reg;
    reg       clk_last_reg;
    reg       clk_valid_reg;
    reg [`DBG_PKT_BITS-1:0] shift_reg;
    reg [`DBG_PKT_BITS-1:0] tx_reg;
    reg [`DBG_CNT_W-1:0]    cnt_reg;
    wire      rise;

    // pin samples pass two flops first
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clk_sync_reg <= 2'h0;
            din_sync_reg <= 2'h0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[0], dbg_serial_clock};
            din_sync_reg <= {din_sync_reg[0], dbg_serial_in};
        end
    end

    // level accepted only after two equal consecutive samples
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clk_last_reg  <= 1'b0;
            clk_valid_reg <= 1'b0;
        end else begin
            clk_last_reg <= clk_sync_reg[1];
            if (clk_sync_reg[1] == clk_last_reg)
                clk_valid_reg <= clk_last_reg;
        end
    end

    assign rise = (clk_sync_reg[1] == clk_last_reg) && clk_last_reg &&
                  !clk_valid_reg;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg      <= {`DBG_PKT_BITS{1'b0}};
            tx_reg         <= {`DBG_PKT_BITS{1'b0}};
            cnt_reg        <= {`DBG_CNT_W{1'b0}};
            dbg_serial_out <= 1'b0;
            rx_data        <= {`DBG_PKT_BITS{1'b0}};
            rx_valid       <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (rise) begin
                // data is only taken once the clock is seen high
                shift_reg <= {shift_reg[`DBG_PKT_BITS-2:0],
                              din_sync_reg[1]};
                // out bit is registered, so it lags the validated edge
                if (cnt_reg == {`DBG_CNT_W{1'b0}}) begin
                    dbg_serial_out <= resp_data[`DBG_PKT_BITS-1];
                    tx_reg <= {resp_data[`DBG_PKT_BITS-2:0], 1'b0};
                end else begin
                    dbg_serial_out <= tx_reg[`DBG_PKT_BITS-1];
                    tx_reg <= {tx_reg[`DBG_PKT_BITS-2:0], 1'b0};
                end
                if (cnt_reg == `DBG_PKT_BITS - 1) begin
                    cnt_reg  <= {`DBG_CNT_W{1'b0}};
                    rx_data  <= {shift_reg[`DBG_PKT_BITS-2:0],
                                 din_sync_reg[1]};
                    rx_valid <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
            // no else: the out bit holds between validated edges
        end
    end

endmodule
`default_nettype wire

// [core/debug_status_port.v]
// debug access logic: test port, serial debug port, status outputs
`timescale 1ns/1ns
`default_nettype none
`include "debug_status_port_defines.vh"

// Behaviour
// - test-port select level at reset picks debug port or test port.
// - low test reset clears test-port logic asynchronously; here it is synchronised and cleared on mclk, three cycles late.
// - mode select sampled on test clock rise moves the controller.
// - test data input sampled on test clock rise.
// - test data output driven only in shift-IR and shift-DR.
// - test data output changes only on test clock fall.
// - debug clock level accepted after two equal bus-clock samples.
// - on validated debug clock rise, sample input and shift output.
// - serial input is synchronised and used once clock seen high.
// - serial output comes from a register, lagging validation.
// - breakpoint without disable halts after current instruction.
// - halted processor shows 0xf on status and status-data outputs.
// - with disable set, breakpoint raises debug interrupt instead.
// - status clock is delayed processor clock, centred in data; here it is mclk halved.
// - status-clock disable freezes clock and outputs, keeps triggers.
// - status clock idle until first 0xc, 0xd or 0xf status.
// - all-ones output is the AND of the four status bits.
// - debug data outputs show captured data and breakpoint status.
// - status outputs follow core status on the processor clock.

module debug_status_port (
    // clock and reset
    input  wire        mclk,
    input  wire        reset_n,
    // mode strap
    input  wire        test_port_select,
    output reg         test_port_mode,
    // test port pins
    input  wire        test_reset_n,
    input  wire        test_clock,
    input  wire        test_mode_sel,
    input  wire        test_data_in,
    output reg         test_data_out,
    output reg         test_data_oe,
    // debug serial pins
    input  wire        dbg_serial_clock,
    input  wire        dbg_serial_in,
    output wire        dbg_serial_out,
    // debug serial user side
    input  wire [16:0] dbg_resp_data,
    output wire [16:0] dbg_rx_data,
    output wire        dbg_rx_valid,
    // breakpoint and core handshake
    input  wire        breakpoint_request,
    input  wire        breakpoint_disable,
    input  wire        instr_done,
    input  wire        resume,
    output reg         halt_request,
    output reg         processor_halted,
    output reg         debug_interrupt,
    output reg         trigger_hit,
    // core status input
    input  wire [3:0]  core_status,
    input  wire [3:0]  core_data,
    input  wire        status_clock_disable,
    // status outputs
    output reg  [3:0]  proc_status_out,
    output reg  [3:0]  debug_data_out,
    output reg  [7:0]  status_debug_data,
    output wire        status_all_ones,
    output reg         status_clock
);

    // synchronisers for the test-port pins and the breakpoint request
    reg [1:0] trst_sync_reg;
    reg [1:0] tck_sync_reg;
    reg [1:0] tms_sync_reg;
    reg [1:0] tdi_sync_reg;
    reg [1:0] breakpoint_request_sync_reg;
    reg       tck_last_reg;
    reg       strap_seen_reg;
    wire      tck_rise;
    wire      tck_fall;
    wire      trst_n;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            trst_sync_reg <= 2'h0;
            tck_sync_reg  <= 2'h0;
            tms_sync_reg  <= 2'h3;
            tdi_sync_reg  <= 2'h3;
            breakpoint_request_sync_reg <= 2'h0;
            tck_last_reg  <= 1'b0;
        end else begin
            trst_sync_reg <= {trst_sync_reg[0], test_reset_n};
            tck_sync_reg  <= {tck_sync_reg[0], test_clock};
            tms_sync_reg  <= {tms_sync_reg[0], test_mode_sel};
            tdi_sync_reg  <= {tdi_sync_reg[0], test_data_in};
            breakpoint_request_sync_reg <= {breakpoint_request_sync_reg[0], breakpoint_request};
            tck_last_reg  <= tck_sync_reg[1];
        end
    end

    assign tck_rise = tck_sync_reg[1] && !tck_last_reg;
    assign tck_fall = !tck_sync_reg[1] && tck_last_reg;
    assign trst_n   = trst_sync_reg[1];

    // strap caught once on the first clock after reset release
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_seen_reg <= 1'b0;
            test_port_mode <= 1'b0;
        end else if (!strap_seen_reg) begin
            strap_seen_reg <= 1'b1;
            test_port_mode <= test_port_select;
        end
    end

    // test-port controller
    reg [3:0]           tap_reg;
    reg [3:0]           tap_next;
    reg [`IR_WIDTH-1:0] ir_shift_reg;
    reg [`IR_WIDTH-1:0] ir_reg;
    reg [3:0]           dr_shift_reg;
    reg                 bypass_reg;
    wire                tms;
    wire                shifting;

    assign tms = tms_sync_reg[1];

    always @* begin
        case (tap_reg)
            `TAP_RESET:    tap_next = tms ? `TAP_RESET   : `TAP_IDLE;
            `TAP_IDLE:     tap_next = tms ? `TAP_SEL_DR  : `TAP_IDLE;
            `TAP_SEL_DR:   tap_next = tms ? `TAP_SEL_IR  : `TAP_CAP_DR;
            `TAP_CAP_DR:   tap_next = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
            `TAP_SHIFT_DR: tap_next = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
            `TAP_EXIT1_DR: tap_next = tms ? `TAP_UPD_DR  : `TAP_PAUSE_DR;
            `TAP_PAUSE_DR: tap_next = tms ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
            `TAP_EXIT2_DR: tap_next = tms ? `TAP_UPD_DR  : `TAP_SHIFT_DR;
            `TAP_UPD_DR:   tap_next = tms ? `TAP_SEL_DR  : `TAP_IDLE;
            `TAP_SEL_IR:   tap_next = tms ? `TAP_RESET   : `TAP_CAP_IR;
            `TAP_CAP_IR:   tap_next = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
            `TAP_SHIFT_IR: tap_next = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
            `TAP_EXIT1_IR: tap_next = tms ? `TAP_UPD_IR  : `TAP_PAUSE_IR;
            `TAP_PAUSE_IR: tap_next = tms ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
            `TAP_EXIT2_IR: tap_next = tms ? `TAP_UPD_IR  : `TAP_SHIFT_IR;
            `TAP_UPD_IR:   tap_next = tms ? `TAP_SEL_DR  : `TAP_IDLE;
            default:       tap_next = `TAP_RESET;
        endcase
    end

    assign shifting = (tap_reg == `TAP_SHIFT_IR) ||
                      (tap_reg == `TAP_SHIFT_DR);

    // test reset pin clears the port on its own, no test clock needed;
    // the pin is sampled on mclk, so the clear lags the pin by three cycles
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tap_reg      <= `TAP_RESET;
            ir_shift_reg <= {`IR_WIDTH{1'b0}};
            ir_reg       <= `IR_RESET_VAL;
            dr_shift_reg <= 4'h0;
            bypass_reg   <= 1'b0;
        end else if (!trst_n || !test_port_mode) begin
            tap_reg      <= `TAP_RESET;
            ir_reg       <= `IR_RESET_VAL;
            bypass_reg   <= 1'b0;
        end else if (tck_rise) begin
            tap_reg <= tap_next;
            case (tap_reg)
                `TAP_CAP_IR: ir_shift_reg <= `IR_CAPTURE;
                `TAP_SHIFT_IR: ir_shift_reg <=
                    {tdi_sync_reg[1], ir_shift_reg[`IR_WIDTH-1:1]};
                `TAP_UPD_IR: ir_reg <= ir_shift_reg;
                `TAP_CAP_DR: begin
                    bypass_reg   <= 1'b0;
                    dr_shift_reg <= core_status;
                end
                `TAP_SHIFT_DR: begin
                    bypass_reg   <= tdi_sync_reg[1];
                    dr_shift_reg <= {tdi_sync_reg[1], dr_shift_reg[3:1]};
                end
                default: ir_shift_reg <= ir_shift_reg;
            endcase
        end
    end

    // output bit moves only on the test clock fall; its enable also clears on test reset or outside test-port mode
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            test_data_out <= 1'b0;
            test_data_oe  <= 1'b0;
        end else if (!trst_n || !test_port_mode) begin
            test_data_oe  <= 1'b0;
        end else if (tck_fall) begin
            test_data_oe <= shifting;
            if (tap_reg == `TAP_SHIFT_IR)
                test_data_out <= ir_shift_reg[0];
            else if (ir_reg == `IR_BYPASS)
                test_data_out <= bypass_reg;
            else
                test_data_out <= dr_shift_reg[0];
        end
    end

    // debug serial port, idle while the pins serve the test port;
    // the debugger keeps its clock at or under a fifth of status clock
    wire dbg_serial_clock_gated;
    assign dbg_serial_clock_gated = dbg_serial_clock & ~test_port_mode;

    dbg_serial_port u_serial (
        .mclk             (mclk),
        .reset_n          (reset_n),
        .dbg_serial_clock (dbg_serial_clock_gated),
        .dbg_serial_in    (dbg_serial_in),
        .dbg_serial_out   (dbg_serial_out),
        .resp_data        (dbg_resp_data),
        .rx_data          (dbg_rx_data),
        .rx_valid         (dbg_rx_valid)
    );

    // breakpoint handling
    reg breakpoint_request_last_reg;
    reg halt_pend_reg;
    wire breakpoint_request_rise;
    assign breakpoint_request_rise = breakpoint_request_sync_reg[1] && !breakpoint_request_last_reg;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            breakpoint_request_last_reg    <= 1'b0;
            halt_pend_reg    <= 1'b0;
            halt_request     <= 1'b0;
            processor_halted <= 1'b0;
            debug_interrupt  <= 1'b0;
            trigger_hit      <= 1'b0;
        end else begin
            breakpoint_request_last_reg   <= breakpoint_request_sync_reg[1];
            debug_interrupt <= breakpoint_request_rise && breakpoint_disable;
            // triggers stay live even while the status clock is off
            trigger_hit     <= breakpoint_request_rise;
            halt_request <= halt_pend_reg && !processor_halted;
            if (halt_pend_reg && instr_done) begin
                processor_halted <= 1'b1;
                halt_pend_reg    <= 1'b0;
            end else if (resume) begin
                processor_halted <= 1'b0;
            end
            if (breakpoint_request_rise && !breakpoint_disable)
                halt_pend_reg <= 1'b1;
        end
    end

    // status path: half-rate status clock rises mid data interval
    reg       div_reg;
    reg       started_reg;
    reg [3:0] status_now;
    wire      status_en;

    always @* begin
        status_now = processor_halted ? `PST_HALTED : core_status;
    end

    assign status_en = div_reg;
    assign status_all_ones = &proc_status_out;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg           <= 1'b0;
            started_reg       <= 1'b0;
            status_clock      <= 1'b0;
            proc_status_out   <= `PST_IDLE;
            debug_data_out    <= 4'h0;
            status_debug_data <= 8'h00;
        end else begin
            div_reg <= ~div_reg;
            if (status_now == `PST_START_C || status_now == `PST_START_D ||
                status_now == `PST_HALTED)
                started_reg <= 1'b1;
            // frozen outputs cost the debugger a resync afterwards
            if (!status_clock_disable) begin
                if (status_en) begin
                    proc_status_out <= status_now;
                    debug_data_out  <= processor_halted ? `PST_HALTED :
                                       (trigger_hit ? 4'h1 :
                                        core_data);
                    status_debug_data <= processor_halted ? 8'hff :
                                         {status_now, core_data};
                    status_clock <= 1'b0;
                end else begin
                    status_clock <= started_reg;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [verification/debug_status_port_asserts.sv]
// checker: timing relations at the debug status port pins
`timescale 1ns/1ns
`default_nettype none
module debug_status_port_asserts (
    // clock and reset
    input wire logic       mclk,
    input wire logic       reset_n,
    // test port
    input wire logic       test_port_mode,
    input wire logic       test_clock,
    input wire logic       test_data_out,
    input wire logic       test_data_oe,
    // debug serial
    input wire logic       dbg_serial_clock,
    input wire logic       dbg_serial_out,
    // breakpoint
    input wire logic       breakpoint_disable,
    input wire logic       instr_done,
    input wire logic       halt_request,
    input wire logic       processor_halted,
    input wire logic       debug_interrupt,
    // status
    input wire logic [3:0] core_status,
    input wire logic       status_clock_disable,
    input wire logic [3:0] proc_status_out,
    input wire logic [7:0] status_debug_data,
    input wire logic       status_all_ones,
    input wire logic       status_clock
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // set once a start value (c, d or f) or a halt has been seen
    logic seen_reg;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            seen_reg <= 1'b0;
        else if ((core_status[3:2] == 2'b11 && core_status != 4'he)
                 || processor_halted)
            seen_reg <= 1'b1;
    end
    sequence s_done;
        halt_request && instr_done;
    endsequence
    sequence s_halted;
        (processor_halted && !status_clock_disable) [*4];
    endsequence
    a_all_ones_and: assert property (status_all_ones == &proc_status_out)
        else $error("all-ones output differs from status AND");
    a_oe_test_mode: assert property (test_data_oe |-> test_port_mode)
        else $error("test output driven outside test-port mode");
    a_tdo_on_fall: assert property (($changed(test_data_out) || $changed(test_data_oe)) |-> !$past(test_clock))
        else $error("test output moved while test clock high");
    a_serial_out_rise: assert property ($changed(dbg_serial_out) |-> $past(dbg_serial_clock) && $past(dbg_serial_clock, 2))
        else $error("serial output moved without validated clock");
    a_halt_after_done: assert property (s_done |=> processor_halted)
        else $error("no halt after instruction end");
    a_halt_needs_done: assert property ($rose(processor_halted) |-> $past(instr_done))
        else $error("halt before instruction end");
    a_halted_shows_f: assert property (s_halted |-> proc_status_out == 4'hf && status_debug_data == 8'hff)
        else $error("halted status value wrong");
    a_irq_needs_disable: assert property (debug_interrupt |-> $past(breakpoint_disable) && !processor_halted)
        else $error("debug interrupt without disable");
    a_frozen_outputs: assert property (status_clock_disable [*3] |-> $stable(status_clock) && $stable(proc_status_out))
        else $error("status outputs toggled while disabled");
    a_clock_idle: assert property (!seen_reg |-> !status_clock)
        else $error("status clock ran before start value");
endmodule
bind debug_status_port debug_status_port_asserts chk (
    .mclk(mclk), .reset_n(reset_n), .test_port_mode(test_port_mode),
    .test_clock(test_clock), .test_data_out(test_data_out),
    .test_data_oe(test_data_oe), .dbg_serial_clock(dbg_serial_clock),
    .dbg_serial_out(dbg_serial_out), .breakpoint_disable(breakpoint_disable),
    .instr_done(instr_done), .halt_request(halt_request),
    .processor_halted(processor_halted), .debug_interrupt(debug_interrupt),
    .core_status(core_status), .status_clock_disable(status_clock_disable),
    .proc_status_out(proc_status_out), .status_debug_data(status_debug_data),
    .status_all_ones(status_all_ones), .status_clock(status_clock));
`default_nettype wire

// [verification/dbg_host_model.sv]
// partner model: external debugger on the test port and serial pins
`timescale 1ns/1ns
`default_nettype none
module dbg_host_model (
    // test port
    output logic      test_clock,
    output logic      test_mode_sel,
    output logic      test_data_in,
    input  wire logic tdo_pin,
    // debug serial
    output logic      dbg_serial_clock,
    output logic      dbg_serial_in,
    input  wire logic dbg_serial_out
);
    // both clocks stand still low between calls
    initial begin
        test_clock = 1'b0;
        test_mode_sel = 1'b0;
        test_data_in = 1'b0;
        dbg_serial_clock = 1'b0;
        dbg_serial_in = 1'b0;
    end
    task automatic tap_seq(input int n, input logic [15:0] tms,
                           input logic [15:0] tdi, output logic [15:0] tdo);
        tdo = 16'h0000;
        for (int i = 0; i < n; i++) begin
            test_mode_sel = tms[i];
            test_data_in = tdi[i];
            #80 test_clock = 1'b1;
            // output only moves on the fall, so late in the high phase is safe
            #70 tdo[i] = tdo_pin;
            #10 test_clock = 1'b0;
        end
        test_data_in = ~test_data_in;
    endtask
    // 240 ns bit period keeps the clock under a fifth of the status clock
    task automatic ser_word(input logic [16:0] tx, output logic [16:0] rx);
        rx = 17'h00000;
        for (int i = 16; i >= 0; i--) begin
            dbg_serial_in = tx[i];
            #120 dbg_serial_clock = 1'b1;
            #115 rx[i] = dbg_serial_out;
            #5 dbg_serial_clock = 1'b0;
        end
        dbg_serial_in = ~dbg_serial_in;
        #120;
    endtask
endmodule
`default_nettype wire

// [verification/test_debug_status_port.sv]
// testbench: debug status port against a behavioural model
`timescale 1ns/1ns
`default_nettype none
module test_debug_status_port;
    logic        mclk, reset_n, test_port_select, test_reset_n;
    logic        breakpoint_request, breakpoint_disable, instr_done, resume;
    logic        status_clock_disable, irq_seen;
    logic [3:0]  core_status, core_data, v;
    logic [16:0] dbg_resp_data, tx, rsp;
    logic [15:0] tdo;
    logic [7:0]  d;
    wire         test_clock, test_mode_sel, test_data_in, test_data_out;
    wire         test_data_oe, test_port_mode, dbg_serial_clock, dbg_serial_in;
    wire         dbg_serial_out, dbg_rx_valid, halt_request, processor_halted;
    wire         debug_interrupt, status_all_ones, status_clock;
    wire [16:0]  dbg_rx_data;
    wire [3:0]   proc_status_out, debug_data_out;
    wire [7:0]   status_debug_data;
    // the released test output line is pulled up
    wire         tdo_pin = test_data_oe ? test_data_out : 1'b1;
    logic [16:0] rxq[$];
    integer      seed, err_count, tests_run, i;

    debug_status_port dut (.mclk(mclk), .reset_n(reset_n),
        .test_port_select(test_port_select), .test_port_mode(test_port_mode),
        .test_reset_n(test_reset_n), .test_clock(test_clock),
        .test_mode_sel(test_mode_sel), .test_data_in(test_data_in),
        .test_data_out(test_data_out), .test_data_oe(test_data_oe),
        .dbg_serial_clock(dbg_serial_clock), .dbg_serial_in(dbg_serial_in),
        .dbg_serial_out(dbg_serial_out), .dbg_resp_data(dbg_resp_data),
        .dbg_rx_data(dbg_rx_data), .dbg_rx_valid(dbg_rx_valid),
        .breakpoint_request(breakpoint_request),
        .breakpoint_disable(breakpoint_disable), .instr_done(instr_done),
        .resume(resume), .halt_request(halt_request),
        .processor_halted(processor_halted), .debug_interrupt(debug_interrupt),
        .trigger_hit(), .core_status(core_status), .core_data(core_data),
        .status_clock_disable(status_clock_disable),
        .proc_status_out(proc_status_out), .debug_data_out(debug_data_out),
        .status_debug_data(status_debug_data),
        .status_all_ones(status_all_ones), .status_clock(status_clock));
    dbg_host_model mdl (.test_clock(test_clock), .test_mode_sel(test_mode_sel),
        .test_data_in(test_data_in), .tdo_pin(tdo_pin),
        .dbg_serial_clock(dbg_serial_clock), .dbg_serial_in(dbg_serial_in),
        .dbg_serial_out(dbg_serial_out));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // pulses are caught here so waits on the falling edge cannot miss them
    always @(posedge mclk) begin
        if (dbg_rx_valid === 1'b1) rxq.push_back(dbg_rx_data);
        if (debug_interrupt === 1'b1) irq_seen <= 1'b1;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [16:0] exp,
                         input logic [16:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: pick = halt_request;
            1: pick = processor_halted;
            2: pick = irq_seen;
            default: pick = status_clock;
        endcase
    endfunction
    task automatic wait_hi(input int sel);
        int n;
        n = 0;
        while (n < 300 && pick(sel) !== 1'b1) begin
            @(negedge mclk);
            n++;
        end
        tests_run++;
        if (n == 300) begin
            err_count++;
            $display("BAD wait %0d expected 1 seen 0", sel);
            results();
        end
    endtask

    initial begin
        seed = 43200; err_count = 0; tests_run = 0; irq_seen = 1'b0;
        reset_n = 1'b0; test_port_select = 1'b0; test_reset_n = 1'b1;
        breakpoint_request = 1'b0; breakpoint_disable = 1'b0;
        instr_done = 1'b0; resume = 1'b0; status_clock_disable = 1'b0;
        core_status = 4'h0; core_data = 4'h0; dbg_resp_data = 17'h00000;
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        repeat (20) @(negedge mclk);
        check("mode", 0, test_port_mode);
        check("idle clock", 0, status_clock);
        core_status = 4'hc;
        wait_hi(3);
        for (i = 0; i < 4; i++) begin
            core_status = $random(seed);
            core_data = $random(seed);
            repeat (4) @(negedge mclk);
            check("status", core_status, proc_status_out);
            check("all ones", &core_status, status_all_ones);
            check("data", core_data, debug_data_out);
        end
        status_clock_disable = 1'b1;
        repeat (2) @(negedge mclk);
        v = proc_status_out;
        core_status = ~core_status;
        repeat (6) @(negedge mclk);
        check("frozen", v, proc_status_out);
        status_clock_disable = 1'b0;
        wait_hi(3);
        repeat (4) @(negedge mclk);
        check("thawed", core_status, proc_status_out);
        for (i = 0; i < 3; i++) begin
            dbg_resp_data = $random(seed);
            tx = $random(seed);
            #3;
            mdl.ser_word(tx, rsp);
            repeat (4) @(negedge mclk);
            check("reply", dbg_resp_data, rsp);
            check("rx count", 1, rxq.size());
            check("rx word", tx, rxq.pop_front());
        end
        breakpoint_disable = 1'b1;
        breakpoint_request = 1'b1;
        wait_hi(2);
        breakpoint_request = 1'b0;
        check("no halt", 0, processor_halted);
        repeat (4) @(negedge mclk);
        breakpoint_disable = 1'b0;
        breakpoint_request = 1'b1;
        wait_hi(0);
        repeat (5) @(negedge mclk);
        check("early halt", 0, processor_halted);
        instr_done = 1'b1;
        @(negedge mclk);
        instr_done = 1'b0;
        wait_hi(1);
        repeat (4) @(negedge mclk);
        check("halt status", 4'hf, proc_status_out);
        check("halt data", 8'hff, status_debug_data);
        check("halt ones", 1, status_all_ones);
        check("halt dd", 4'hf, debug_data_out);
        breakpoint_request = 1'b0;
        resume = 1'b1;
        @(negedge mclk);
        resume = 1'b0;
        repeat (4) @(negedge mclk);
        check("resume", 0, processor_halted);
        reset_n = 1'b0;
        test_port_select = 1'b1;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        check("test mode", 1, test_port_mode);
        #3;
        mdl.tap_seq(11, 16'h0306, 16'h01e0, tdo);
        check("ir capture", 4'h1, tdo[8:5]);
        check("idle oe", 0, test_data_oe);
        d = $random(seed);
        mdl.tap_seq(11, 16'h0001, {5'h00, d, 3'h0}, tdo);
        check("bypass", {d[6:0], 1'b0}, tdo[10:3]);
        repeat (8) @(negedge mclk);
        check("shift oe", 1, test_data_oe);
        test_reset_n = 1'b0;
        repeat (8) @(negedge mclk);
        check("reset oe", 0, test_data_oe);
        test_reset_n = 1'b1;
        results();
    end
endmodule
`default_nettype wire
